// *** design/servo_output_terminal_logic.sv ***
/*
 * Output terminal function logic: status functions, drive enable sequence, selectable outputs,
 * register port and interrupt. Assumes every drive_state_s field is synchronous to clk.
 */
// Local design decisions: the register addresses and strobed register access.
module servo_output_terminal_logic #(
	parameter int unsigned TICK_CYC = servo_out_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire servo_out_pkg::reg_req_s reg_req,
	output logic [15:0] rdata,
	input wire servo_out_pkg::drive_state_s drive,
	output logic phys_output_one,
	output logic phys_output_two,
	output logic phys_output_three,
	output logic [15:0] comm_output_bits,
	output logic base_on,
	output logic irq
);
	typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_HOLD} seq_e;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	seq_e state_q;
	seq_e state_d;
	logic alarm_q;
	logic arst_prev_q;
	logic loaded_q;
	logic [7:0] sel_sh_q [servo_out_pkg::N_OUT];
	logic [7:0] sel_act_q [servo_out_pkg::N_OUT];
	logic [servo_out_pkg::N_OUT-1:0] out_q;
	logic inpos_fmt_q;
	logic [15:0] brake_dly_q;
	logic [15:0] max_ps_q;
	logic [15:0] max_tq_q;
	logic tq_lim_sel_q;
	logic [15:0] step_q [servo_out_pkg::N_STEP];
	logic [servo_out_pkg::N_EV-1:0] irq_stat_q;
	logic [servo_out_pkg::N_EV-1:0] irq_en_q;
	logic [servo_out_pkg::N_EV-1:0] ev_prev_q;
	logic [servo_out_pkg::N_EV-1:0] ev_now;
	logic [31:0] tick_q;
	logic [15:0] ms_q;
	logic hold_done;
	logic inpos_lvl_q;
	logic inpos_prev_q;
	logic ovw_q;
	logic teach_prev_q;
	logic inpos_fn;
	logic ready_fn;
	logic brake_fn;
	logic spdlim_fn;
	logic ovw_fn;
	logic ready_cond;
	logic [15:0] spd_lim;
	logic [127:0] fn_vec;
	logic [15:0] rdata_q;
	logic [15:0] rd_mux;

	// servo enable sequence
	assign ready_cond = drive.servo_on && drive.emergency_stop_in && !drive.coast_request_in
		&& !alarm_q && !drive.fault && drive.ctrl_ready;
	assign hold_done = (ms_q >= brake_dly_q);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF: begin
				if (ready_cond) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (drive.fault || alarm_q) begin
					state_d = ST_OFF;
				end else if (!drive.servo_on) begin
					state_d = ST_HOLD;
				end else if (!ready_cond) begin
					state_d = ST_OFF;
				end
			end
			ST_HOLD: begin
				// base stays on through the delay so the motor holds while the brake closes
				if (drive.fault || alarm_q || hold_done) begin
					state_d = ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// millisecond timer for the hold delay; runs only in the hold state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 32'h0;
			ms_q <= 16'h0;
		end else if (state_q != ST_HOLD) begin
			tick_q <= 32'h0;
			ms_q <= 16'h0;
		end else if (tick_q == TICK_CYC - 1) begin
			tick_q <= 32'h0;
			ms_q <= ms_q + 16'h1;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end

	assign base_on = (state_q != ST_OFF);
	assign ready_fn = (state_q != ST_OFF);
	assign brake_fn = (state_q == ST_RUN);

	// alarm latch: a fault in the reset cycle keeps the alarm
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_q <= 1'b0;
			arst_prev_q <= 1'b0;
		end else begin
			arst_prev_q <= drive.alarm_reset;
			if (drive.fault) begin
				alarm_q <= 1'b1;
			end else if (drive.alarm_reset && !arst_prev_q) begin
				alarm_q <= 1'b0;
			end
		end
	end

	// in-position level and single shot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inpos_lvl_q <= 1'b0;
			inpos_prev_q <= 1'b0;
		end else begin
			inpos_prev_q <= inpos_lvl_q;
			if (alarm_q || drive.fault) begin
				inpos_lvl_q <= 1'b0;
			end else if (drive.motion_done) begin
				inpos_lvl_q <= 1'b1;
			end else if (drive.motion_start) begin
				inpos_lvl_q <= 1'b0;
			end
		end
	end

	always_comb begin
		if (drive.mode != servo_out_pkg::MODE_POS) begin
			inpos_fn = 1'b1;
		end else if (inpos_fmt_q) begin
			inpos_fn = inpos_lvl_q && !inpos_prev_q;
		end else begin
			inpos_fn = inpos_lvl_q;
		end
	end

	// speed limit selection
	always_comb begin
		if (drive.mode == servo_out_pkg::MODE_TORQUE) begin
			spd_lim = tq_lim_sel_q ? step_q[drive.speed_step_select] : max_tq_q;
		end else begin
			spd_lim = max_ps_q;
		end
	end
	// command pulse operation has no limit detection
	assign spdlim_fn = !(drive.mode == servo_out_pkg::MODE_POS && drive.pulse_op)
		&& (drive.motor_speed >= spd_lim);

	// overwrite completion, re-armed when a new teach entry begins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovw_q <= 1'b0;
			teach_prev_q <= 1'b0;
		end else begin
			teach_prev_q <= drive.teach_entry;
			if (drive.overwrite_done) begin
				ovw_q <= 1'b1;
			end else if (drive.teach_entry && !teach_prev_q) begin
				ovw_q <= 1'b0;
			end
		end
	end
	assign ovw_fn = ovw_q || drive.teach_entry;

	// function table indexed by code; unlisted codes read low
	always_comb begin
		fn_vec = 128'h0;
		fn_vec[servo_out_pkg::FN_READY] = ready_fn;
		fn_vec[servo_out_pkg::FN_INPOS] = inpos_fn;
		fn_vec[servo_out_pkg::FN_SPDLIM] = spdlim_fn;
		fn_vec[servo_out_pkg::FN_OVW] = ovw_fn;
		fn_vec[servo_out_pkg::FN_BRAKE] = brake_fn;
		fn_vec[servo_out_pkg::FN_ALM_NO] = alarm_q;
		fn_vec[servo_out_pkg::FN_ALM_NC] = !alarm_q;
		fn_vec[servo_out_pkg::FN_CTRL_RDY] = drive.ctrl_ready;
		fn_vec[servo_out_pkg::FN_ALM_CODE +: 5] = drive.alarm_code;
		fn_vec[servo_out_pkg::FN_MODE +: 8] = drive.mode_bits;
	end

	// selections: shadow copies are what software sees; active copies load once after power-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loaded_q <= 1'b0;
		end else begin
			loaded_q <= 1'b1;
		end
	end

	for (genvar i = 0; i < servo_out_pkg::N_OUT; i++) begin : g_out
		localparam logic [7:0] ADDR = (i < servo_out_pkg::N_PHYS) ? 8'(servo_out_pkg::ADDR_SEL1 + i)
			: 8'(servo_out_pkg::ADDR_COMM_BASE + i - servo_out_pkg::N_PHYS);
		localparam logic [7:0] RST = (i == 0) ? servo_out_pkg::SEL1_RST : (i == 1) ? servo_out_pkg::SEL2_RST
			: (i == 2) ? servo_out_pkg::SEL3_RST : servo_out_pkg::COMM_SEL_RST;
		// non-volatile copy: rst_n stands for a power cycle, so a written selection must survive it
		logic [7:0] sh_q = RST;
		always_ff @(posedge clk) begin
			if (reg_req.wr && reg_req.addr == ADDR) begin
				sh_q <= reg_req.wdata[7:0];
			end
		end
		assign sel_sh_q[i] = sh_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sel_act_q[i] <= RST;
			end else if (!loaded_q) begin
				sel_act_q[i] <= sel_sh_q[i];
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				out_q[i] <= 1'b0;
			end else begin
				out_q[i] <= !sel_act_q[i][7] && fn_vec[sel_act_q[i][6:0]];
			end
		end
	end

	assign phys_output_one = out_q[0];
	assign phys_output_two = out_q[1];
	assign phys_output_three = out_q[2];
	assign comm_output_bits = out_q[servo_out_pkg::N_OUT-1:servo_out_pkg::N_PHYS];

	// settings registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inpos_fmt_q <= servo_out_pkg::INPOS_FMT_RST;
			brake_dly_q <= servo_out_pkg::BRAKE_DLY_RST;
			max_ps_q <= servo_out_pkg::MAX_PS_RST;
			max_tq_q <= servo_out_pkg::MAX_TQ_RST;
			tq_lim_sel_q <= servo_out_pkg::TQ_LIM_SEL_RST;
		end else if (reg_req.wr) begin
			unique case (reg_req.addr)
				servo_out_pkg::ADDR_INPOS_FMT: inpos_fmt_q <= reg_req.wdata[0];
				servo_out_pkg::ADDR_BRAKE_DLY: brake_dly_q <= reg_req.wdata;
				servo_out_pkg::ADDR_MAX_PS: max_ps_q <= reg_req.wdata;
				servo_out_pkg::ADDR_MAX_TQ: max_tq_q <= reg_req.wdata;
				servo_out_pkg::ADDR_TQ_LIM_SEL: tq_lim_sel_q <= reg_req.wdata[0];
				default: ;
			endcase
		end
	end

	for (genvar s = 0; s < servo_out_pkg::N_STEP; s++) begin : g_step
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				step_q[s] <= servo_out_pkg::STEP_RST;
			end else if (reg_req.wr && reg_req.addr == 8'(servo_out_pkg::ADDR_STEP_BASE + s)) begin
				step_q[s] <= reg_req.wdata;
			end
		end
	end

	// interrupt: rising edges set sticky bits; a set in the clear cycle wins
	assign ev_now = {ovw_fn, spdlim_fn, inpos_fn, alarm_q};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_prev_q <= '0;
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			ev_prev_q <= ev_now;
			if (reg_req.wr && reg_req.addr == servo_out_pkg::ADDR_IRQ_EN) begin
				irq_en_q <= reg_req.wdata[servo_out_pkg::N_EV-1:0];
			end
			if (reg_req.wr && reg_req.addr == servo_out_pkg::ADDR_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~reg_req.wdata[servo_out_pkg::N_EV-1:0]) | (ev_now & ~ev_prev_q);
			end else begin
				irq_stat_q <= irq_stat_q | (ev_now & ~ev_prev_q);
			end
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// read port
	always_comb begin
		rd_mux = 16'h0;
		unique case (reg_req.addr)
			servo_out_pkg::ADDR_INPOS_FMT: rd_mux = {15'h0, inpos_fmt_q};
			servo_out_pkg::ADDR_BRAKE_DLY: rd_mux = brake_dly_q;
			servo_out_pkg::ADDR_MAX_PS: rd_mux = max_ps_q;
			servo_out_pkg::ADDR_MAX_TQ: rd_mux = max_tq_q;
			servo_out_pkg::ADDR_TQ_LIM_SEL: rd_mux = {15'h0, tq_lim_sel_q};
			servo_out_pkg::ADDR_IRQ_STAT: rd_mux = {12'h0, irq_stat_q};
			servo_out_pkg::ADDR_IRQ_EN: rd_mux = {12'h0, irq_en_q};
			servo_out_pkg::ADDR_STATE: rd_mux = {9'h0, base_on, brake_fn, ready_fn, alarm_q, inpos_fn,
				spdlim_fn, ovw_fn};
			default: ;
		endcase
		for (int k = 0; k < servo_out_pkg::N_OUT; k++) begin
			if (reg_req.addr == ((k < servo_out_pkg::N_PHYS) ? 8'(servo_out_pkg::ADDR_SEL1 + k)
				: 8'(servo_out_pkg::ADDR_COMM_BASE + k - servo_out_pkg::N_PHYS))) begin
				rd_mux = {8'h0, sel_sh_q[k]};
			end
		end
		for (int k = 0; k < servo_out_pkg::N_STEP; k++) begin
			if (reg_req.addr == 8'(servo_out_pkg::ADDR_STEP_BASE + k)) begin
				rd_mux = step_q[k];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0;
		end else begin
			rdata_q <= reg_req.rd ? rd_mux : 16'h0;
		end
	end
	assign rdata = rdata_q;

	// checks
	a_sel_frozen_run: assert property (loaded_q && reg_req.wr |=> $stable(sel_act_q[0]))
		else $error("output selection changed during operation");
	a_out_one_map: assert property (loaded_q && sel_act_q[0] == 8'h01 |=> phys_output_one == $past(ready_fn))
		else $error("output one does not follow its function");
	a_alarm_kills_drive: assert property (drive.fault |=> !base_on && !brake_fn && !ready_fn)
		else $error("drive outputs stay on after fault");
	a_ready_needs_cond: assert property ($rose(ready_fn) |-> $past(ready_cond))
		else $error("ready rose without conditions");
	a_brake_on_off: assert property (!drive.servo_on |=> !brake_fn)
		else $error("brake released with servo enable off");
	a_ready_hold_delay: assert property (state_q == ST_RUN && !drive.servo_on && !drive.fault && !alarm_q
		&& brake_dly_q != 16'h0 |=> ready_fn && !brake_fn [*2])
		else $error("ready dropped before hold delay");
	a_inpos_nonpos: assert property (drive.mode != servo_out_pkg::MODE_POS |-> inpos_fn)
		else $error("in-position low outside position mode");
	a_inpos_alarm: assert property (alarm_q |=> !inpos_lvl_q)
		else $error("in-position held through alarm");
	a_inpos_pulse: assert property (inpos_fmt_q && drive.mode == servo_out_pkg::MODE_POS && inpos_fn
		|=> !inpos_fn || drive.mode != servo_out_pkg::MODE_POS || !$stable(inpos_fmt_q))
		else $error("single shot in-position longer than one cycle");
	a_inpos_done: assert property (drive.motion_done && !drive.fault && !alarm_q |=> inpos_lvl_q)
		else $error("in-position not set after completion");
	a_speed_limit: assert property (drive.mode == servo_out_pkg::MODE_SPEED && drive.motor_speed >= max_ps_q
		|-> spdlim_fn)
		else $error("speed limit missed");
	a_ovw_teach: assert property (drive.overwrite_done ##1 !drive.teach_entry |-> ovw_fn)
		else $error("overwrite completion not held");
	a_alarm_latch: assert property (drive.fault ##1 !(drive.alarm_reset && !arst_prev_q) |-> ##1 alarm_q)
		else $error("alarm latch lost");
endmodule

// *** shared/servo_out_pkg.sv ***
/*
 * Constants, types and register map of the servo output terminal logic.
 * Assumes one 20 MHz drive clock and a plain register port with a word index address.
 */
package servo_out_pkg;
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned N_PHYS = 3;
	localparam int unsigned N_COMM = 16;
	localparam int unsigned N_OUT = N_PHYS + N_COMM;
	localparam int unsigned N_STEP = 8;
	localparam int unsigned N_EV = 4;

	localparam logic [7:0] ADDR_SEL1 = 8'h00;
	localparam logic [7:0] ADDR_INPOS_FMT = 8'h03;
	localparam logic [7:0] ADDR_BRAKE_DLY = 8'h04;
	localparam logic [7:0] ADDR_MAX_PS = 8'h05;
	localparam logic [7:0] ADDR_MAX_TQ = 8'h06;
	localparam logic [7:0] ADDR_TQ_LIM_SEL = 8'h07;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h09;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0A;
	localparam logic [7:0] ADDR_STATE = 8'h0B;
	localparam logic [7:0] ADDR_COMM_BASE = 8'h10;
	localparam logic [7:0] ADDR_STEP_BASE = 8'h20;

	localparam logic [7:0] SEL1_RST = 8'h01;
	localparam logic [7:0] SEL2_RST = 8'h02;
	localparam logic [7:0] SEL3_RST = 8'h4C;
	localparam logic [7:0] COMM_SEL_RST = 8'h00;
	localparam logic INPOS_FMT_RST = 1'b0;
	localparam logic [15:0] BRAKE_DLY_RST = 16'h0064;
	localparam logic [15:0] MAX_PS_RST = 16'h1388;
	localparam logic [15:0] MAX_TQ_RST = 16'h1388;
	localparam logic TQ_LIM_SEL_RST = 1'b0;
	localparam logic [15:0] STEP_RST = 16'h03E8;

	localparam logic [6:0] FN_READY = 7'h01;
	localparam logic [6:0] FN_INPOS = 7'h02;
	localparam logic [6:0] FN_SPDLIM = 7'h0B;
	localparam logic [6:0] FN_OVW = 7'h0D;
	localparam logic [6:0] FN_BRAKE = 7'h0E;
	localparam logic [6:0] FN_ALM_NO = 7'h10;
	localparam logic [6:0] FN_CTRL_RDY = 7'h1C;
	localparam logic [6:0] FN_ALM_CODE = 7'h20;
	localparam logic [6:0] FN_MODE = 7'h3C;
	localparam logic [6:0] FN_ALM_NC = 7'h4C;

	localparam int unsigned EV_ALARM = 0;
	localparam int unsigned EV_INPOS = 1;
	localparam int unsigned EV_SPDLIM = 2;
	localparam int unsigned EV_OVW = 3;

	typedef enum logic [1:0] {MODE_POS, MODE_SPEED, MODE_TORQUE} ctrl_mode_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic servo_on;
		logic emergency_stop_in;
		logic coast_request_in;
		logic ctrl_ready;
		logic fault;
		logic alarm_reset;
		logic motion_start;
		logic motion_done;
		logic pulse_op;
		logic overwrite_done;
		logic teach_entry;
		logic [2:0] speed_step_select;
		logic [4:0] alarm_code;
		logic [7:0] mode_bits;
		ctrl_mode_e mode;
		logic [15:0] motor_speed;
	} drive_state_s;
endpackage

// *** testbench/drive_core_model.sv ***
/*
 * Far-side model of the drive core: puts the commanded servo state onto the block's drive port.
 * Assumes the bench changes cmd by non-blocking assignment right after rising edges of clk.
 */
module drive_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire servo_out_pkg::drive_state_s cmd,
	output servo_out_pkg::drive_state_s drive
);
	timeunit 1ns;
	timeprecision 1ns;
	servo_out_pkg::drive_state_s prev_q;
	servo_out_pkg::drive_state_s nxt;
	// event fields become one-cycle pulses, so a held command bit never repeats an event
	always_comb begin
		nxt = cmd;
		nxt.motion_start = cmd.motion_start & ~prev_q.motion_start;
		nxt.motion_done = cmd.motion_done & ~prev_q.motion_done;
		nxt.overwrite_done = cmd.overwrite_done & ~prev_q.overwrite_done;
		nxt.alarm_reset = cmd.alarm_reset & ~prev_q.alarm_reset;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
			drive <= '0;
		end else begin
			prev_q <= cmd;
			drive <= nxt;
		end
	end
endmodule

// *** testbench/test_servo_output_terminal_logic.sv ***
/*
 * Self-checking bench of the output terminal logic: register port, selections, status functions.
 * Assumes selection shadows keep their contents across rst_n, which stands in for power cycling.
 */
module test_servo_output_terminal_logic;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TICK = 4;
	typedef struct packed {
		logic [20:0] v;
		logic [20:0] m;
	} note_s;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic samp = 1'h0;
	logic rd_seen = 1'h0;
	servo_out_pkg::reg_req_s req = '0;
	servo_out_pkg::drive_state_s cmd = '0;
	servo_out_pkg::drive_state_s drive;
	logic [15:0] rdata;
	logic [15:0] comm;
	logic p1, p2, p3, base_on, irq;
	note_s q[$];
	note_s e;
	int fails = 0;
	int num_checks = 0;
	int seed = 32'hB850;
	int cnt;
	logic [7:0] tbl [16] = '{8'h0E, 8'h0B, 8'h0D, 8'h10, 8'h1C, 8'h20, 8'h21, 8'h22,
		8'h23, 8'h24, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41};

	always #25 clk = ~clk;

	servo_output_terminal_logic #(.TICK_CYC(TICK)) servo_output_terminal_logic_i (
		.clk(clk), .rst_n(rst_n), .reg_req(req), .rdata(rdata), .drive(drive),
		.phys_output_one(p1), .phys_output_two(p2), .phys_output_three(p3),
		.comm_output_bits(comm), .base_on(base_on), .irq(irq));
	drive_core_model drive_core_model_i (.clk(clk), .rst_n(rst_n), .cmd(cmd), .drive(drive));

	task check(input string name, input logic [20:0] seen, input logic [20:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// read results show one cycle after the strobe that asked for them, pin samples in the strobe cycle itself, oldest note first
	always @(posedge clk) begin
		rd_seen <= req.rd;
		if (rd_seen === 1'h1) begin
			e = q.pop_front();
			check("rdata", {5'h00, rdata} & e.m, e.v & e.m);
		end
		if (samp === 1'h1) begin
			e = q.pop_front();
			check("pins", {p1, p2, p3, comm, base_on, irq} & e.m, e.v & e.m);
		end
	end

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req.wr <= 1'h1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] m);
		@(posedge clk);
		req.rd <= 1'h1;
		req.addr <= a;
		q.push_back('{{5'h00, v}, {5'h00, m}});
		@(posedge clk);
		req.rd <= 1'h0;
	endtask

	task pins(input logic [20:0] v, input logic [20:0] m);
		@(posedge clk);
		samp <= 1'h1;
		q.push_back('{v, m});
		@(posedge clk);
		samp <= 1'h0;
	endtask

	task spd(input servo_out_pkg::ctrl_mode_e md, input logic [2:0] st, input logic [15:0] s, input logic x);
		cmd.mode <= md;
		cmd.speed_step_select <= st;
		cmd.motor_speed <= s;
		cyc(4);
		pins({3'h2, 14'h0000, x, 1'h0, 2'h0}, {3'h2, 14'h0000, 1'h1, 1'h0, 2'h0});
	endtask

	initial begin
		cyc(20000);
		fails++;
		end_of_test();
	end

	initial begin
		cyc(10);
		rst_n <= 1'h1;
		cyc(2);
		rd(servo_out_pkg::ADDR_SEL1, 16'h0001, 16'hFFFF);
		rd(8'h01, 16'h0002, 16'hFFFF);
		rd(8'h02, 16'h004C, 16'hFFFF);
		for (int i = 0; i < 16; i++) begin
			rd(servo_out_pkg::ADDR_COMM_BASE + 8'(i), 16'h0000, 16'hFFFF);
		end
		wr(8'h30, 16'hFFFF);
		rd(8'h30, 16'h0000, 16'hFFFF);
		rd(servo_out_pkg::ADDR_IRQ_CLR, 16'h0000, 16'hFFFF);
		wr(8'h02, 16'h0010);
		rd(8'h02, 16'h0010, 16'hFFFF);
		for (int i = 0; i < 16; i++) begin
			wr(servo_out_pkg::ADDR_COMM_BASE + 8'(i), {8'h00, tbl[i]});
		end
		cmd.servo_on <= 1'h1;
		cmd.emergency_stop_in <= 1'h1;
		cmd.ctrl_ready <= 1'h1;
		cmd.motion_done <= 1'h1;
		cyc(5);
		pins({3'h7, 16'h0000, 2'h2}, {3'h7, 16'hFFFF, 2'h2});
		rst_n <= 1'h0;
		cmd.motion_done <= 1'h0;
		cmd.mode_bits <= 8'hA5;
		cmd.alarm_code <= 5'h0A;
		cyc(2);
		rst_n <= 1'h1;
		cmd.motion_done <= 1'h1;
		cyc(5);
		pins({3'h6, 16'h9551, 2'h2}, {3'h7, 16'hFFFF, 2'h2});
		for (int k = 0; k < 3; k++) begin
			case (k)
				0: cmd.emergency_stop_in <= 1'h0;
				1: cmd.coast_request_in <= 1'h1;
				default: cmd.ctrl_ready <= 1'h0;
			endcase
			cyc(4);
			pins({3'h2, 16'h0000, 2'h0}, {3'h6, 16'h0000, 2'h0});
			cmd.emergency_stop_in <= 1'h1;
			cmd.coast_request_in <= 1'h0;
			cmd.ctrl_ready <= 1'h1;
			cyc(4);
			pins({3'h4, 16'h0000, 2'h0}, {3'h4, 16'h0000, 2'h0});
		end
		repeat (4) begin
			spd(servo_out_pkg::MODE_POS, 3'h0, 16'($random(seed)) & 16'h0FFF, 1'h0);
			spd(servo_out_pkg::MODE_POS, 3'h0, 16'h1388 + (16'($random(seed)) & 16'h0FFF), 1'h1);
		end
		cmd.pulse_op <= 1'h1;
		spd(servo_out_pkg::MODE_POS, 3'h0, 16'h2000, 1'h0);
		cmd.pulse_op <= 1'h0;
		wr(servo_out_pkg::ADDR_MAX_TQ, 16'h0800);
		spd(servo_out_pkg::MODE_TORQUE, 3'h0, 16'h0900, 1'h1);
		spd(servo_out_pkg::MODE_TORQUE, 3'h0, 16'h07FF, 1'h0);
		wr(servo_out_pkg::ADDR_STEP_BASE + 8'h03, 16'h0100);
		wr(servo_out_pkg::ADDR_TQ_LIM_SEL, 16'h0001);
		spd(servo_out_pkg::MODE_TORQUE, 3'h3, 16'h0200, 1'h1);
		spd(servo_out_pkg::MODE_TORQUE, 3'h0, 16'h0200, 1'h0);
		spd(servo_out_pkg::MODE_SPEED, 3'h3, 16'h0200, 1'h0);
		spd(servo_out_pkg::MODE_SPEED, 3'h3, servo_out_pkg::MAX_PS_RST, 1'h1);
		spd(servo_out_pkg::MODE_POS, 3'h0, 16'h0000, 1'h0);
		cmd.motion_done <= 1'h0;
		cmd.motion_start <= 1'h1;
		cyc(4);
		pins({3'h0, 16'h0000, 2'h0}, {3'h2, 16'h0000, 2'h0});
		cmd.motion_start <= 1'h0;
		cmd.motion_done <= 1'h1;
		cyc(4);
		pins({3'h2, 16'h0000, 2'h0}, {3'h2, 16'h0000, 2'h0});
		wr(servo_out_pkg::ADDR_BRAKE_DLY, 16'h0004);
		cmd.servo_on <= 1'h0;
		cyc(4);
		pins({3'h2, 16'h0000, 2'h0}, {3'h2, 16'h0000, 2'h0});
		cmd.servo_on <= 1'h1;
		cyc(4);
		pins({3'h2, 16'h0000, 2'h0}, {3'h2, 16'h0000, 2'h0});
		wr(servo_out_pkg::ADDR_INPOS_FMT, 16'h0001);
		cmd.motion_done <= 1'h0;
		cmd.motion_start <= 1'h1;
		cyc(4);
		cmd.motion_start <= 1'h0;
		cmd.motion_done <= 1'h1;
		cnt = 0;
		repeat (12) begin
			@(posedge clk);
			cnt += (p2 === 1'h1);
		end
		check("pulse count", cnt[20:0], 21'h000001);
		wr(servo_out_pkg::ADDR_INPOS_FMT, 16'h0000);
		cmd.teach_entry <= 1'h1;
		cyc(4);
		pins({3'h0, 16'h0004, 2'h0}, {3'h0, 16'h0004, 2'h0});
		cmd.teach_entry <= 1'h0;
		cmd.overwrite_done <= 1'h1;
		cyc(4);
		pins({3'h0, 16'h0004, 2'h0}, {3'h0, 16'h0004, 2'h0});
		cmd.overwrite_done <= 1'h0;
		cmd.servo_on <= 1'h0;
		cyc(5);
		pins({3'h4, 16'h0000, 2'h2}, {3'h4, 16'h0001, 2'h2});
		cyc(30);
		pins({3'h0, 16'h0000, 2'h0}, {3'h4, 16'h0001, 2'h2});
		cmd.servo_on <= 1'h1;
		cyc(4);
		pins({3'h4, 16'h0001, 2'h2}, {3'h4, 16'h0001, 2'h2});
		wr(servo_out_pkg::ADDR_IRQ_CLR, 16'h000F);
		wr(servo_out_pkg::ADDR_IRQ_EN, 16'h0000);
		cmd.fault <= 1'h1;
		cyc(3);
		pins({3'h1, 16'h0008, 2'h0}, {3'h5, 16'h0009, 2'h3});
		rd(servo_out_pkg::ADDR_IRQ_STAT, 16'h0001, 16'h0001);
		cmd.alarm_reset <= 1'h1;
		cyc(2);
		cmd.alarm_reset <= 1'h0;
		cyc(3);
		pins({3'h0, 16'h0008, 2'h0}, {3'h0, 16'h0008, 2'h0});
		cmd.fault <= 1'h0;
		cyc(4);
		pins({3'h0, 16'h0008, 2'h0}, {3'h0, 16'h0008, 2'h0});
		cmd.alarm_reset <= 1'h1;
		cyc(2);
		cmd.alarm_reset <= 1'h0;
		cyc(3);
		pins({3'h0, 16'h0000, 2'h0}, {3'h1, 16'h0008, 2'h0});
		wr(servo_out_pkg::ADDR_IRQ_EN, 16'h0001);
		pins({3'h0, 16'h0000, 2'h1}, {3'h0, 16'h0000, 2'h1});
		wr(servo_out_pkg::ADDR_IRQ_CLR, 16'h0001);
		pins({3'h0, 16'h0000, 2'h0}, {3'h0, 16'h0000, 2'h1});
		rd(servo_out_pkg::ADDR_IRQ_STAT, 16'h0000, 16'h0001);
		cyc(2);
		end_of_test();
	end
endmodule
